// file: pkg/nav_defs.svh
// Constants for the navigation-state packet encoder
// Overview of operation
// - Geodetic position: id 32, 24 bytes, latitude, longitude, height as fp64.
// - Earth-centred position: id 33, 24 bytes, X, Y, Z as fp64.
// - Grid position: id 34, 26 bytes, three fp64, zone number, zone letter.
// - North-east-down velocity: id 35, 12 bytes, three fp32 in order.
// - Body velocity: id 36, 12 bytes, X, Y, Z fp32 at 0, 4, 8.
// - Acceleration: id 37, 12 bytes, X, Y, Z as fp32.
// - Body acceleration: id 38, 16 bytes, X, Y, Z, g-force fp32.
// - Euler orientation: id 39, 12 bytes, roll, pitch, heading fp32.
// - Quaternion orientation: id 40, 16 bytes, components 0 to 3 fp32.
// - Direction cosine matrix: id 41, 36 bytes, nine fp32 row-major.
`ifndef NAV_DEFS_SVH
`define NAV_DEFS_SVH

`define NAV_ID_GEO 8'h20
`define NAV_ID_ECEF 8'h21
`define NAV_ID_GRID 8'h22
`define NAV_ID_NED 8'h23
`define NAV_ID_BVEL 8'h24
`define NAV_ID_ACC 8'h25
`define NAV_ID_BACC 8'h26
`define NAV_ID_EUL 8'h27
`define NAV_ID_QUAT 8'h28
`define NAV_ID_DCM 8'h29

`define NAV_LEN_GEO 6'h18
`define NAV_LEN_ECEF 6'h18
`define NAV_LEN_GRID 6'h1A
`define NAV_LEN_NED 6'h0C
`define NAV_LEN_BVEL 6'h0C
`define NAV_LEN_ACC 6'h0C
`define NAV_LEN_BACC 6'h10
`define NAV_LEN_EUL 6'h0C
`define NAV_LEN_QUAT 6'h10
`define NAV_LEN_DCM 6'h24

// Word index of each packet's first field in the solution store; fp64 is low word first
`define NAV_BASE_GEO 6'h00
`define NAV_BASE_ECEF 6'h06
`define NAV_BASE_GRID 6'h0C
`define NAV_BASE_NED 6'h13
`define NAV_BASE_BVEL 6'h16
`define NAV_BASE_ACC 6'h19
`define NAV_BASE_BACC 6'h1C
`define NAV_BASE_EUL 6'h20
`define NAV_BASE_QUAT 6'h23
`define NAV_BASE_DCM 6'h27
`define NAV_SOL_WORDS 6'h30

`define NAV_FIFO_DEPTH 4
`define NAV_FIFO_WIDTH 10

`endif

// file: pkg/nav_pkg.sv
// Types for the navigation-state packet encoder
package nav_pkg;
  typedef enum logic {ST_IDLE, ST_SEND} enc_state_t;
endpackage : nav_pkg

// file: design/nav_byte_fifo.sv
// Shift-register FIFO whose head, valid and ready all come from flip-flops
`timescale 1ns/1ps
module nav_byte_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 4
) (
  input wire logic clk_in, // System clock
  input wire logic resetn_in, // Asynchronous reset, active low
  input wire logic wr_valid_in, // Write request
  output logic wr_ready_out, // Room for a word
  input wire logic [WIDTH-1:0] wr_data_in, // Write data
  output logic rd_valid_out, // Head word present
  input wire logic rd_ready_in, // Head word taken
  output logic [WIDTH-1:0] rd_data_out // Head word
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [$clog2(DEPTH+1)-1:0] count;
  logic push;
  logic pop;
  logic [$clog2(DEPTH+1)-1:0] next_count;

  assign push = wr_valid_in && wr_ready_out;
  assign pop = rd_valid_out && rd_ready_in;
  assign next_count = count + push - pop;

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count <= '0;
      rd_valid_out <= 1'b0;
      wr_ready_out <= 1'b1;
    end else begin
      count <= next_count;
      rd_valid_out <= (next_count != '0);
      wr_ready_out <= (next_count != DEPTH[$clog2(DEPTH+1)-1:0]);
    end
  end

  // Head always sits in slot zero so the output needs no read mux
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem[i] <= '0;
      end
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        if (push && (i == int'(count) - int'(pop))) begin
          mem[i] <= wr_data_in;
        end else if (pop && i < DEPTH - 1) begin
          mem[i] <= mem[i+1];
        end
      end
    end
  end

  assign rd_data_out = mem[0];

  chk_full_blocks: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (count == DEPTH[$clog2(DEPTH+1)-1:0]) |-> !wr_ready_out)
    else $error("fifo offers room while full");
endmodule : nav_byte_fifo

// file: design/nav_state_packet_encoder.sv
// Navigation-state packet payload encoder with solution snapshot and byte FIFO
`timescale 1ns/1ps
`include "nav_defs.svh"
module nav_state_packet_encoder
  import nav_pkg::*;
(
  input wire logic sys_clk_in, // 100 MHz system clock
  input wire logic resetn_in, // Asynchronous reset, active low
  input wire logic sol_wr_in, // Write one solution word to the staging copy
  input wire logic [5:0] sol_addr_in, // Solution word index
  input wire logic [31:0] sol_data_in, // Solution word
  input wire logic sol_commit_in, // Staged words form one solution instant
  input wire logic req_valid_in, // Packet request
  input wire logic [7:0] req_id_in, // Requested packet identifier
  output logic req_ready_out, // Request can be taken
  output logic req_reject_out, // Pulse: unknown identifier refused
  output logic [7:0] pkt_id_out, // Identifier of packet in flight
  output logic [5:0] pkt_len_out, // Payload length of packet in flight
  output logic out_valid_out, // Payload byte valid
  input wire logic out_ready_in, // Framing stage takes the byte
  output logic [7:0] out_data_out, // Payload byte
  output logic out_first_out, // Byte is the first of the payload
  output logic out_last_out // Byte is the last of the payload
);
  function automatic logic [5:0] pkt_len(input logic [7:0] id);
    case (id)
      `NAV_ID_GEO: pkt_len = `NAV_LEN_GEO;
      `NAV_ID_ECEF: pkt_len = `NAV_LEN_ECEF;
      `NAV_ID_GRID: pkt_len = `NAV_LEN_GRID;
      `NAV_ID_NED: pkt_len = `NAV_LEN_NED;
      `NAV_ID_BVEL: pkt_len = `NAV_LEN_BVEL;
      `NAV_ID_ACC: pkt_len = `NAV_LEN_ACC;
      `NAV_ID_BACC: pkt_len = `NAV_LEN_BACC;
      `NAV_ID_EUL: pkt_len = `NAV_LEN_EUL;
      `NAV_ID_QUAT: pkt_len = `NAV_LEN_QUAT;
      `NAV_ID_DCM: pkt_len = `NAV_LEN_DCM;
      default: pkt_len = 6'h00;
    endcase
  endfunction : pkt_len

  function automatic logic [5:0] pkt_base(input logic [7:0] id);
    case (id)
      `NAV_ID_GEO: pkt_base = `NAV_BASE_GEO;
      `NAV_ID_ECEF: pkt_base = `NAV_BASE_ECEF;
      `NAV_ID_GRID: pkt_base = `NAV_BASE_GRID;
      `NAV_ID_NED: pkt_base = `NAV_BASE_NED;
      `NAV_ID_BVEL: pkt_base = `NAV_BASE_BVEL;
      `NAV_ID_ACC: pkt_base = `NAV_BASE_ACC;
      `NAV_ID_BACC: pkt_base = `NAV_BASE_BACC;
      `NAV_ID_EUL: pkt_base = `NAV_BASE_EUL;
      `NAV_ID_QUAT: pkt_base = `NAV_BASE_QUAT;
      `NAV_ID_DCM: pkt_base = `NAV_BASE_DCM;
      default: pkt_base = 6'h00;
    endcase
  endfunction : pkt_base

  ////////////////////////////////////////////////////////////////////////////
  logic [31:0] stage_mem [`NAV_SOL_WORDS];
  logic [31:0] live_mem [`NAV_SOL_WORDS];
  enc_state_t state;
  logic commit_pending;
  logic copy_now;
  logic take;
  logic accept;
  logic [5:0] base;
  logic [5:0] byte_cnt;
  logic [5:0] word_idx;
  logic [7:0] cur_byte;
  logic push;
  logic is_last;
  logic fifo_ready;
  logic [9:0] fifo_rd;
  logic fifo_empty;

  assign take = req_valid_in && req_ready_out;
  assign accept = take && (pkt_len(req_id_in) != 6'h00);
  // A commit seen mid-packet waits so one payload never mixes two instants
  assign copy_now = (sol_commit_in || commit_pending) && (state != ST_SEND);

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < `NAV_SOL_WORDS; i++) begin
        stage_mem[i] <= 32'h0000_0000;
      end
    end else if (sol_wr_in && sol_addr_in < `NAV_SOL_WORDS) begin
      stage_mem[sol_addr_in] <= sol_data_in;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int i = 0; i < `NAV_SOL_WORDS; i++) begin
        live_mem[i] <= 32'h0000_0000;
      end
    end else if (copy_now) begin
      live_mem <= stage_mem;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      commit_pending <= 1'b0;
    end else if (sol_commit_in && state == ST_SEND) begin
      commit_pending <= 1'b1;
    end else if (copy_now) begin
      commit_pending <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fields are stored in payload order, so byte n of the payload is byte n%4 of word n/4
  assign word_idx = base + {2'b00, byte_cnt[5:2]};
  assign cur_byte = live_mem[word_idx][8*byte_cnt[1:0] +: 8];
  assign push = (state == ST_SEND) && fifo_ready;
  assign is_last = (byte_cnt == pkt_len_out - 6'h01);

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state <= ST_IDLE;
      byte_cnt <= 6'h00;
    end else begin
      case (state)
        ST_IDLE: begin
          byte_cnt <= 6'h00;
          if (accept) begin
            state <= ST_SEND;
          end
        end
        ST_SEND: begin
          if (push) begin
            byte_cnt <= byte_cnt + 6'h01;
            if (is_last) begin
              state <= ST_IDLE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pkt_id_out <= 8'h00;
      pkt_len_out <= 6'h00;
      base <= 6'h00;
    end else if (accept) begin
      pkt_id_out <= req_id_in;
      pkt_len_out <= pkt_len(req_id_in);
      base <= pkt_base(req_id_in);
    end
  end

  // New requests wait for the FIFO to drain so id and length match the bytes leaving
  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      req_ready_out <= 1'b0;
      req_reject_out <= 1'b0;
    end else begin
      req_ready_out <= (state == ST_IDLE) && !accept && fifo_empty;
      req_reject_out <= take && !accept;
    end
  end

  nav_byte_fifo #(
    .WIDTH(`NAV_FIFO_WIDTH),
    .DEPTH(`NAV_FIFO_DEPTH)
  ) u_fifo (
    .clk_in(sys_clk_in),
    .resetn_in(resetn_in),
    .wr_valid_in(push),
    .wr_ready_out(fifo_ready),
    .wr_data_in({byte_cnt == 6'h00, is_last, cur_byte}),
    .rd_valid_out(out_valid_out),
    .rd_ready_in(out_ready_in),
    .rd_data_out(fifo_rd)
  );

  assign fifo_empty = !out_valid_out;
  assign out_first_out = fifo_rd[9];
  assign out_last_out = fifo_rd[8];
  assign out_data_out = fifo_rd[7:0];

  ////////////////////////////////////////////////////////////////////////////
  chk_geo_len: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    take && req_id_in == 8'h20 |=> pkt_len_out == 6'h18 && pkt_id_out == 8'h20)
    else $error("geodetic packet length wrong");
  chk_ecef_len: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    take && req_id_in == 8'h21 |=> pkt_len_out == 6'h18 && state == ST_SEND)
    else $error("earth-centred packet length wrong");
  chk_grid_len: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    take && req_id_in == 8'h22 |=> pkt_len_out == 6'h1A ##0 base == 6'h0C)
    else $error("grid packet length or base wrong");
  chk_ned_len: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    take && req_id_in == 8'h23 |=> pkt_len_out == 6'h0C)
    else $error("velocity packet length wrong");
  chk_bvel_len: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    take && req_id_in == 8'h24 |=> pkt_len_out == 6'h0C && base == 6'h16)
    else $error("body velocity packet layout wrong");
  chk_acc_len: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    take && req_id_in == 8'h25 |=> pkt_len_out == 6'h0C)
    else $error("acceleration packet length wrong");
  chk_bacc_len: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    take && req_id_in == 8'h26 |=> pkt_len_out == 6'h10)
    else $error("body acceleration packet length wrong");
  chk_eul_len: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    take && req_id_in == 8'h27 |=> pkt_len_out == 6'h0C)
    else $error("euler packet length wrong");
  chk_quat_len: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    take && req_id_in == 8'h28 |=> pkt_len_out == 6'h10)
    else $error("quaternion packet length wrong");
  chk_dcm_len: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    take && req_id_in == 8'h29 |=> pkt_len_out == 6'h24 && base == 6'h27)
    else $error("matrix packet layout wrong");
  // Recomputed by shifting the addressed word, not by reusing the byte select
  chk_byte_order: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    push |-> cur_byte == 8'(live_mem[base + 6'(byte_cnt >> 2)] >> (8 * byte_cnt[1:0])))
    else $error("field not sent low byte first");
  chk_last_count: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    push && is_last |=> state == ST_IDLE && byte_cnt == pkt_len_out)
    else $error("packet did not end at its length");
  // Word index must hold too, or the two samples would name different words
  chk_snapshot_hold: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    state == ST_SEND && $past(state) == ST_SEND && $stable(word_idx)
      |-> $stable(live_mem[word_idx]))
    else $error("solution changed inside a packet");
  chk_commit_later: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
    sol_commit_in && state == ST_SEND |=> commit_pending)
    else $error("commit during packet was lost");

  cov_grid: cover property (@(posedge sys_clk_in) disable iff (!resetn_in)
    accept && req_id_in == 8'h22 ##[1:60] push && is_last);
  cov_stall: cover property (@(posedge sys_clk_in) disable iff (!resetn_in)
    state == ST_SEND && !fifo_ready);
  cov_reject: cover property (@(posedge sys_clk_in) disable iff (!resetn_in) req_reject_out);
  cov_defer: cover property (@(posedge sys_clk_in) disable iff (!resetn_in)
    commit_pending ##[1:60] copy_now);
endmodule : nav_state_packet_encoder

// file: sim/nav_host_model.sv
// Host-side receiver model that takes payload bytes and logs them with their flags
`timescale 1ns/1ps
module nav_host_model (
  input wire logic clk_in, // System clock
  input wire logic resetn_in, // Asynchronous reset, active low
  input wire logic stall_in, // Take only one byte in four when high
  input wire logic out_valid_in, // Payload byte valid
  input wire logic [7:0] out_data_in, // Payload byte
  input wire logic out_first_in, // First byte flag
  input wire logic out_last_in, // Last byte flag
  output logic out_ready_out, // Host takes the byte
  output int count_out // Bytes taken since reset
);
  logic [7:0] data_log [0:1023];
  logic [1:0] flag_log [0:1023];
  logic [1:0] pace;

  ////////////////////////////////////////////////////////////////////////////////
  // Ready changes only at the falling edge, so the sampling edge never races it
  always @(negedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pace <= 2'h0;
      out_ready_out <= 1'b0;
    end else begin
      pace <= pace + 2'h1;
      out_ready_out <= !stall_in || (pace == 2'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bytes are logged in arrival order, least significant byte of each field first
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      count_out <= 0;
    end else if (out_valid_in && out_ready_out) begin
      data_log[count_out[9:0]] <= out_data_in;
      flag_log[count_out[9:0]] <= {out_first_in, out_last_in};
      count_out <= count_out + 1;
    end
  end
endmodule : nav_host_model

// file: sim/nav_state_packet_encoder_bench.sv
// Self-checking bench for the navigation-state packet encoder
`timescale 1ns/1ps
module nav_state_packet_encoder_bench;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic sol_wr_in = 1'b0;
  logic [5:0] sol_addr_in = 6'h00;
  logic [31:0] sol_data_in = 32'h0;
  logic sol_commit_in = 1'b0;
  logic req_valid_in = 1'b0;
  logic [7:0] req_id_in = 8'h00;
  logic req_ready_out, req_reject_out, out_valid_out, out_ready_in, out_first_out, out_last_out;
  logic [7:0] pkt_id_out, out_data_out;
  logic [5:0] pkt_len_out;
  logic stall = 1'b0;
  int host_count;
  int fails = 0;
  int num_checks = 0;
  logic [31:0] mirror [0:47];
  int lens [0:9] = '{24, 24, 26, 12, 12, 12, 16, 12, 16, 36};
  int bases [0:9];

  always #5 sys_clk_in = ~sys_clk_in;

  nav_state_packet_encoder u_dut (.sys_clk_in(sys_clk_in), .resetn_in(resetn_in),
    .sol_wr_in(sol_wr_in), .sol_addr_in(sol_addr_in), .sol_data_in(sol_data_in),
    .sol_commit_in(sol_commit_in), .req_valid_in(req_valid_in), .req_id_in(req_id_in),
    .req_ready_out(req_ready_out), .req_reject_out(req_reject_out), .pkt_id_out(pkt_id_out),
    .pkt_len_out(pkt_len_out), .out_valid_out(out_valid_out), .out_ready_in(out_ready_in),
    .out_data_out(out_data_out), .out_first_out(out_first_out), .out_last_out(out_last_out));

  nav_host_model u_host (.clk_in(sys_clk_in), .resetn_in(resetn_in), .stall_in(stall),
    .out_valid_in(out_valid_out), .out_data_in(out_data_out), .out_first_in(out_first_out),
    .out_last_in(out_last_out), .out_ready_out(out_ready_in), .count_out(host_count));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [63:0] seen, input logic [63:0] expect_v);
    num_checks++;
    if (seen !== expect_v) begin
      fails++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, expect_v);
    end
  endtask : check

  task automatic summarize();
    if (fails == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  // Writes words lo..hi with a pattern keyed by s, then commits; mirror follows if track
  task automatic load_words(input int lo, input int hi, input logic [7:0] s, input bit track);
    for (int i = lo; i <= hi; i++) begin
      @(negedge sys_clk_in);
      sol_wr_in = 1'b1;
      sol_addr_in = 6'(i);
      sol_data_in = {s, 8'(i), ~8'(i), 8'(i) ^ s};
      if (track) mirror[i] = sol_data_in;
    end
    @(negedge sys_clk_in);
    sol_wr_in = 1'b0;
    sol_commit_in = 1'b1;
    @(negedge sys_clk_in);
    sol_commit_in = 1'b0;
  endtask : load_words

  // Presents one request and holds it until the edge that takes it
  task automatic request(input logic [7:0] id);
    int n;
    n = 0;
    req_valid_in = 1'b1;
    req_id_in = id;
    while (req_ready_out !== 1'b1 && n < 500) begin
      @(negedge sys_clk_in);
      n++;
    end
    check(n < 500, 1'b1);
    @(negedge sys_clk_in);
    req_valid_in = 1'b0;
  endtask : request

  // Sends packet k; if upd, a new solution is written while its bytes are in flight
  task automatic send_pkt(input int k, input bit upd);
    int start;
    int n;
    start = host_count;
    @(negedge sys_clk_in);
    request(8'(32 + k));
    check({pkt_id_out, 2'b00, pkt_len_out}, {8'(32 + k), 8'(lens[k])});
    if (upd) load_words(bases[k], bases[k] + 5, 8'hC3, 1'b0);
    n = 0;
    while (host_count < start + lens[k] && n < 1000) begin
      @(negedge sys_clk_in);
      n++;
    end
    check(host_count, start + lens[k]);
    for (int b = 0; b < lens[k]; b++) begin
      check(u_host.data_log[start + b], mirror[bases[k] + b / 4][8 * (b % 4) +: 8]);
      check(u_host.flag_log[start + b], {b == 0, b == lens[k] - 1});
    end
  endtask : send_pkt

  ////////////////////////////////////////////////////////////////////////////////
  // Ids 32 to 41 with a prompt host: identifiers, lengths, field order and offsets
  task automatic test_all_types();
    stall = 1'b0;
    for (int k = 0; k < 10; k++) send_pkt(k, 1'b0);
  endtask : test_all_types

  // Slow host fills the FIFO; the longest packet and the 26-byte grid packet that ends part-way through a word
  task automatic test_stalled();
    stall = 1'b1;
    send_pkt(9, 1'b0);
    send_pkt(2, 1'b0);
    stall = 1'b0;
  endtask : test_stalled

  // Ids just outside the range are refused with a one-cycle pulse and no bytes
  task automatic test_reject();
    logic [7:0] bad [0:1] = '{8'h1F, 8'h2A};
    int start;
    for (int j = 0; j < 2; j++) begin
      start = host_count;
      @(negedge sys_clk_in);
      request(bad[j]);
      check(req_reject_out, 1'b1);
      @(negedge sys_clk_in);
      check(req_reject_out, 1'b0);
      repeat (4) @(negedge sys_clk_in);
      check(host_count, start);
    end
  endtask : test_reject

  // A commit in mid-packet must not mix instants; the next packet sees the new data
  task automatic test_snapshot();
    stall = 1'b1;
    send_pkt(0, 1'b1);
    for (int i = 0; i < 6; i++) mirror[i] = {8'hC3, 8'(i), ~8'(i), 8'(i) ^ 8'hC3};
    stall = 1'b0;
    send_pkt(0, 1'b0);
  endtask : test_snapshot

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    bases[0] = 0;
    for (int k = 1; k < 10; k++) bases[k] = bases[k - 1] + (lens[k - 1] + 3) / 4;
    repeat (20) @(negedge sys_clk_in);
    resetn_in = 1'b1;
    load_words(0, 47, 8'h5A, 1'b1);
    test_all_types();
    test_stalled();
    test_reject();
    test_snapshot();
    summarize();
  end

  // Whole run needs under a thousand cycles; this 20000-cycle margin only catches a hang
  initial begin
    #200us;
    fails++;
    summarize();
  end
endmodule : nav_state_packet_encoder_bench
